/* hdl/tcc_consts.vh */
`ifndef TCC_CONSTS_VH
`define TCC_CONSTS_VH

// ------------------------------------------------------------
// Register offsets (byte addresses, channel stride 0x40)
// ------------------------------------------------------------
`define TCC_CH_STRIDE 8'h40
`define TCC_OFF_CMD 6'h00
`define TCC_OFF_MODE 6'h04
`define TCC_OFF_CV 6'h10
`define TCC_OFF_RA 6'h14
`define TCC_OFF_RB 6'h18
`define TCC_OFF_RC 6'h1c
`define TCC_OFF_STAT 6'h20
`define TCC_OFF_BCTL 8'hc0
`define TCC_OFF_BCHAIN 8'hc4

// ------------------------------------------------------------
// Command register bits
// ------------------------------------------------------------
`define TCC_CMD_EN 0
`define TCC_CMD_DIS 1
`define TCC_CMD_SOFT_TRIGGER_CMD 2
`define TCC_BCTL_SYNC 0

// ------------------------------------------------------------
// Mode register fields
// ------------------------------------------------------------
`define TCC_MODE_W 20
`define TCC_M_CKS_HI 2
`define TCC_M_CKS_LO 0
`define TCC_M_INV 3
`define TCC_M_BURST_HI 5
`define TCC_M_BURST_LO 4
`define TCC_M_STOP 6
`define TCC_M_DIS 7
`define TCC_M_TEDG_HI 9
`define TCC_M_TEDG_LO 8
`define TCC_M_TSEL_HI 11
`define TCC_M_TSEL_LO 10
`define TCC_M_CTRG 12
`define TCC_M_ETRG 13
`define TCC_M_WAVE 15
`define TCC_M_LDA_HI 17
`define TCC_M_LDA_LO 16
`define TCC_M_LDB_HI 19
`define TCC_M_LDB_LO 18

// ------------------------------------------------------------
// Status bits, widths and reset values
// ------------------------------------------------------------
`define TCC_S_OVF 0
`define TCC_S_LOVR 1
`define TCC_S_CLOCK_ENABLE_CMD 16
`define TCC_CNT_MAX 16'hffff
`define TCC_RST_MODE 20'h00000
`define TCC_RST_WORD 16'h0000
`define TCC_RST_CHAIN 6'h00
`define TCC_PRESC_W 9
`define TCC_RESP_OKAY 2'h0
`define TCC_RESP_SLVERR 2'h2

`endif

/* hdl/tcc_timer_core.v */
// Chosen here: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`include "tcc_consts.vh"
`default_nettype none

module tcc_timer_core #(
  parameter ADDR_W = 8
) (
  input wire clk,
  input wire reset_n,
  input wire [ADDR_W-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [ADDR_W-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire [2:0] extClockPin,
  input wire [2:0] lineAIn,
  input wire [2:0] lineBIn,
  input wire [2:0] periphEvent,
  output wire [2:0] lineAOut,
  output wire [2:0] lineAOe,
  output wire [2:0] lineBOut,
  output wire [2:0] lineBOe
);

  // ----------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------
  reg [1:0] rstSync;
  wire rstN = rstSync[1];

  // Two stages so the release never lands near a clock edge
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rstSync <= 2'h0;
    end else begin
      rstSync <= {rstSync[0], 1'b1};
    end
  end

  // Edge selector: 1 rising, 2 falling, 3 both, 0 none
  function edgeHit;
    input [1:0] sel;
    input cur;
    input prev;
    begin
      case (sel)
        2'h1: edgeHit = cur & ~prev;
        2'h2: edgeHit = ~cur & prev;
        2'h3: edgeHit = cur ^ prev;
        default: edgeHit = 1'b0;
      endcase
    end
  endfunction

  // Mapped address check, used for the response code
  function isMapped;
    input [7:0] a;
    begin
      if (a == `TCC_OFF_BCTL || a == `TCC_OFF_BCHAIN) begin
        isMapped = 1'b1;
      end else if (a[7:6] == 2'h3) begin
        isMapped = 1'b0;
      end else begin
        case (a[5:0])
          `TCC_OFF_CMD, `TCC_OFF_MODE, `TCC_OFF_CV, `TCC_OFF_RA,
          `TCC_OFF_RB, `TCC_OFF_RC, `TCC_OFF_STAT: isMapped = 1'b1;
          default: isMapped = 1'b0;
        endcase
      end
    end
  endfunction

  // ----------------------------------------------------------
  // AXI4-Lite write path
  // ----------------------------------------------------------
  reg awHeld;
  reg wHeld;
  reg [7:0] wrAddr;
  reg [31:0] wrData;
  reg [3:0] wrStrb;
  wire wrFire = awHeld & wHeld & ~s_axi_bvalid;
  wire [31:0] wrMask = {{8{wrStrb[3]}}, {8{wrStrb[2]}},
                        {8{wrStrb[1]}}, {8{wrStrb[0]}}};

  assign s_axi_awready = ~awHeld & ~s_axi_bvalid;
  assign s_axi_wready = ~wHeld & ~s_axi_bvalid;

  // Address and data are caught in either order, answered together
  always @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      wrAddr <= 8'h00;
      wrData <= 32'h00000000;
      wrStrb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `TCC_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld <= 1'b1;
        wrAddr <= s_axi_awaddr[7:0];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld <= 1'b1;
        wrData <= s_axi_wdata;
        wrStrb <= s_axi_wstrb;
      end
      if (wrFire) begin
        awHeld <= 1'b0;
        wHeld <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= isMapped(wrAddr) ? `TCC_RESP_OKAY : `TCC_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------
  // Block level registers and prescaler
  // ----------------------------------------------------------
  reg [5:0] chainSel;
  reg [`TCC_PRESC_W-1:0] presc;
  wire [4:0] prescLvl = {presc[8], presc[6], presc[4], presc[2], presc[0]};
  wire blockSync = wrFire & (wrAddr == `TCC_OFF_BCTL) & wrStrb[0] &
                   wrData[`TCC_BCTL_SYNC];
  wire [2:0] lineA = lineAIn | periphEvent;
  wire [2:0] xc;
  wire rdFire = s_axi_arvalid & s_axi_arready;
  wire [7:0] rdAddr = s_axi_araddr[7:0];
  wire [95:0] chRd;

  // Free running divider gives the five internal clock levels
  always @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      presc <= {`TCC_PRESC_W{1'b0}};
      chainSel <= `TCC_RST_CHAIN;
    end else begin
      presc <= presc + 1'b1;
      if (wrFire && wrAddr == `TCC_OFF_BCHAIN && wrStrb[0]) begin
        chainSel <= wrData[5:0];
      end
    end
  end

  // ----------------------------------------------------------
  // AXI4-Lite read path
  // ----------------------------------------------------------
  assign s_axi_arready = ~s_axi_rvalid;

  // One cycle answer; side effects fire on the accepting edge
  always @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `TCC_RESP_OKAY;
    end else if (rdFire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= isMapped(rdAddr) ? `TCC_RESP_OKAY : `TCC_RESP_SLVERR;
      if (rdAddr == `TCC_OFF_BCHAIN) begin
        s_axi_rdata <= {26'h0000000, chainSel};
      end else if (rdAddr[7:6] == 2'h3) begin
        s_axi_rdata <= 32'h00000000;
      end else begin
        s_axi_rdata <= chRd[32*rdAddr[7:6] +: 32];
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Output controller is not built: lines drive low when enabled
  assign lineAOut = 3'h0;
  assign lineBOut = 3'h0;

  // ----------------------------------------------------------
  // Channels
  // ----------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < 3; i = i + 1) begin : ch
      reg [`TCC_MODE_W-1:0] mode;
      reg [15:0] cnt;
      reg [15:0] ra;
      reg [15:0] rb;
      reg [15:0] rc;
      reg clock_enable_cmd;
      reg running;
      reg pendClr;
      reg ovf;
      reg lovr;
      reg raUnread;
      reg rbUnread;
      reg aSeen;
      reg aFresh;
      reg lvlPrev;
      reg aPrev;
      reg trigPrev;
      reg cMatchEv;

      wire wave = mode[`TCC_M_WAVE];
      wire wrCh = wrFire & (wrAddr[7:6] == i);
      wire rdCh = rdFire & (rdAddr[7:6] == i);
      wire cmdWr = wrCh & (wrAddr[5:0] == `TCC_OFF_CMD) & wrStrb[0];
      wire enCmd = cmdWr & wrData[`TCC_CMD_EN];
      wire disCmd = cmdWr & wrData[`TCC_CMD_DIS];
      wire soft_trigger_cmd = cmdWr & wrData[`TCC_CMD_SOFT_TRIGGER_CMD];
      wire rdStat = rdCh & (rdAddr[5:0] == `TCC_OFF_STAT);
      wire rdRa = rdCh & (rdAddr[5:0] == `TCC_OFF_RA);
      wire rdRb = rdCh & (rdAddr[5:0] == `TCC_OFF_RB);

      // External clock k chains from pin k or another channel's line A
      assign xc[i] = (chainSel[2*i+1:2*i] == 2'h1) ? lineA[(i+1)%3] :
                     (chainSel[2*i+1:2*i] == 2'h2) ? lineA[(i+2)%3] :
                     (chainSel[2*i+1:2*i] == 2'h0) ? extClockPin[i] :
                     1'b0;

      // Clock source, invert and burst gate
      wire [7:0] srcAll = {xc, prescLvl};
      wire srcLvl = srcAll[mode[`TCC_M_CKS_HI:`TCC_M_CKS_LO]];
      wire lvl = srcLvl ^ mode[`TCC_M_INV];
      wire [3:0] burstAll = {xc, 1'b1};
      wire gate = burstAll[mode[`TCC_M_BURST_HI:`TCC_M_BURST_LO]];
      // Sampled edge detect only works for slow external clocks
      wire rise = lvl & ~lvlPrev;

      // External trigger source per mode
      wire [3:0] evAll = {xc, lineBIn[i]};
      wire trigSrc = wave ? evAll[mode[`TCC_M_TSEL_HI:`TCC_M_TSEL_LO]] :
                     (mode[`TCC_M_TSEL_LO] ? lineA[i] : lineBIn[i]);
      wire extHit = edgeHit(mode[`TCC_M_TEDG_HI:`TCC_M_TEDG_LO], trigSrc,
                            trigPrev) &
                    (~wave | mode[`TCC_M_ETRG]);

      // Capture loads with A/B ordering
      wire allowA = ~aSeen | ~aFresh;
      wire loadA = ~wave & allowA &
                   edgeHit(mode[`TCC_M_LDA_HI:`TCC_M_LDA_LO], lineA[i],
                           aPrev);
      wire loadB = ~wave & aFresh & ~loadA &
                   edgeHit(mode[`TCC_M_LDB_HI:`TCC_M_LDB_LO], lineA[i],
                           aPrev);

      // Trigger sources merge; block sync equals a software trigger
      wire trig = soft_trigger_cmd | blockSync |
                  (cMatchEv & mode[`TCC_M_CTRG]) | extHit;
      wire stopEv = mode[`TCC_M_STOP] & (wave ? cMatchEv : loadB);
      wire disEv = mode[`TCC_M_DIS] & (wave ? cMatchEv : loadB);
      // A trigger opens the clock in the same cycle it starts it
      wire tick = rise & gate & clock_enable_cmd & (running | trig);
      wire [15:0] next_cnt = pendClr ? `TCC_RST_WORD : cnt + 16'h0001;

      // Enable state and start/stop state
      always @(posedge clk or negedge rstN) begin
        if (!rstN) begin
          clock_enable_cmd <= 1'b0;
          running <= 1'b0;
        end else begin
          if (disCmd || disEv) begin
            clock_enable_cmd <= 1'b0;
          end else if (enCmd) begin
            clock_enable_cmd <= 1'b1;
          end
          // Start and stop only count while enabled
          if (clock_enable_cmd) begin
            if (trig) begin
              running <= 1'b1;
            end else if (stopEv) begin
              running <= 1'b0;
            end
          end
        end
      end

      // Counter, deferred clear and overflow
      always @(posedge clk or negedge rstN) begin
        if (!rstN) begin
          cnt <= `TCC_RST_WORD;
          pendClr <= 1'b0;
          ovf <= 1'b0;
          cMatchEv <= 1'b0;
          lvlPrev <= 1'b0;
        end else begin
          lvlPrev <= lvl;
          cMatchEv <= tick & (next_cnt == rc);
          if (tick) begin
            cnt <= next_cnt;
          end
          // A new trigger beats the clear of an old one
          if (trig) begin
            pendClr <= 1'b1;
          end else if (tick) begin
            pendClr <= 1'b0;
          end
          // Set wins over the read clear
          if (tick && !pendClr && cnt == `TCC_CNT_MAX) begin
            ovf <= 1'b1;
          end else if (rdStat) begin
            ovf <= 1'b0;
          end
        end
      end

      // Capture sequencing, overrun and register writes
      always @(posedge clk or negedge rstN) begin
        if (!rstN) begin
          mode <= `TCC_RST_MODE;
          ra <= `TCC_RST_WORD;
          rb <= `TCC_RST_WORD;
          rc <= `TCC_RST_WORD;
          lovr <= 1'b0;
          raUnread <= 1'b0;
          rbUnread <= 1'b0;
          aSeen <= 1'b0;
          aFresh <= 1'b0;
          aPrev <= 1'b0;
          trigPrev <= 1'b0;
        end else begin
          aPrev <= lineA[i];
          trigPrev <= trigSrc;
          if (wrCh && wrAddr[5:0] == `TCC_OFF_MODE) begin
            mode <= (mode & ~wrMask[`TCC_MODE_W-1:0]) |
                    (wrData[`TCC_MODE_W-1:0] & wrMask[`TCC_MODE_W-1:0]);
          end
          if (wrCh && wrAddr[5:0] == `TCC_OFF_RC) begin
            rc <= (rc & ~wrMask[15:0]) | (wrData[15:0] & wrMask[15:0]);
          end
          // Hardware capture has priority over a bus write
          if (loadA) begin
            ra <= cnt;
          end else if (wrCh && wave && wrAddr[5:0] == `TCC_OFF_RA) begin
            ra <= (ra & ~wrMask[15:0]) | (wrData[15:0] & wrMask[15:0]);
          end
          if (loadB) begin
            rb <= cnt;
          end else if (wrCh && wave && wrAddr[5:0] == `TCC_OFF_RB) begin
            rb <= (rb & ~wrMask[15:0]) | (wrData[15:0] & wrMask[15:0]);
          end
          // Trigger restarts the A-then-B sequence
          if (trig) begin
            aSeen <= 1'b0;
            aFresh <= 1'b0;
          end else if (loadA) begin
            aSeen <= 1'b1;
            aFresh <= 1'b1;
          end else if (loadB) begin
            aFresh <= 1'b0;
          end
          if (loadA) begin
            raUnread <= 1'b1;
          end else if (rdRa) begin
            raUnread <= 1'b0;
          end
          if (loadB) begin
            rbUnread <= 1'b1;
          end else if (rdRb) begin
            rbUnread <= 1'b0;
          end
          if ((loadA && raUnread) || (loadB && rbUnread)) begin
            lovr <= 1'b1;
          end else if (rdStat) begin
            lovr <= 1'b0;
          end
        end
      end

      // Pin direction follows the wave bit; line B also needs a nonzero TSEL
      assign lineAOe[i] = wave;
      assign lineBOe[i] = wave &
        (mode[`TCC_M_TSEL_HI:`TCC_M_TSEL_LO] != 2'h0);

      // Read word for this channel
      assign chRd[32*i +: 32] =
        (rdAddr[5:0] == `TCC_OFF_MODE) ? {12'h000, mode} :
        (rdAddr[5:0] == `TCC_OFF_CV) ? {16'h0000, cnt} :
        (rdAddr[5:0] == `TCC_OFF_RA) ? {16'h0000, ra} :
        (rdAddr[5:0] == `TCC_OFF_RB) ? {16'h0000, rb} :
        (rdAddr[5:0] == `TCC_OFF_RC) ? {16'h0000, rc} :
        (rdAddr[5:0] == `TCC_OFF_STAT) ?
          {15'h0000, clock_enable_cmd, 14'h0000, lovr, ovf} :
        32'h00000000;
    end
  endgenerate

endmodule

`default_nettype wire

/* dv/tcc_timer_core_sva.sv */
`timescale 1ns/100ps
`default_nettype none
module tcc_core_sva (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [2:0] lineAOe,
  input wire logic [2:0] lineBOe
);
  // One clock domain, so one clocking and one disable
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // ----------------------------------------
  // Bus handshake and line direction
  // ----------------------------------------
  bresp_hold_a: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer changed before taken");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address accepted while answer pending");
  aw_block_a: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  read_lat_a: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  write_lat_a: assert property (s_axi_awvalid && s_axi_awready
    && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  b_oe_sub_a: assert property (
    (lineBOe & ~lineAOe) == 3'b000)
    else $error("line B driven outside wave mode");
  oe_on_write_a: assert property (
    $changed(lineAOe) |-> $rose(s_axi_bvalid))
    else $error("line A direction moved without a write");
endmodule
bind tcc_timer_core tcc_core_sva u_sva (
  .clk(clk), .reset_n(reset_n), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .lineAOe(lineAOe), .lineBOe(lineBOe)
);
`default_nettype wire

/* dv/tcc_sig_src.sv */
`timescale 1ns/100ps
`default_nettype none
module tcc_sig_src (
  input wire logic clk,
  output logic [2:0] extClk,
  output logic [2:0] lineA,
  output logic [2:0] lineB,
  output logic [2:0] evt
);
  // ----------------------------------------
  // Far-side clock, line and event sources
  // ----------------------------------------
  // Everything rests low outside pulses; line B stays an idle input
  initial begin
    extClk = 3'b000;
    lineA = 3'b000;
    lineB = 3'b000;
    evt = 3'b000;
  end
  // Levels of 4 bus clocks, so the rate stays far below the limit
  task automatic clkPulses(input int k, input int n);
    repeat (n) begin
      @(posedge clk);
      extClk[k] <= 1'b1;
      repeat (4) @(posedge clk);
      extClk[k] <= 1'b0;
      repeat (3) @(posedge clk);
    end
    repeat (4) @(posedge clk);
  endtask
  // Pulse on the line A pin or on the event input, 4 clocks wide
  task automatic aPulse(input int k, input bit viaEvt);
    @(posedge clk);
    if (viaEvt) evt[k] <= 1'b1;
    else lineA[k] <= 1'b1;
    repeat (4) @(posedge clk);
    evt[k] <= 1'b0;
    lineA[k] <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
endmodule
`default_nettype wire

/* dv/tcc_timer_core_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module tcc_timer_core_tb;
  logic clk;
  logic reset_n = 1'b0;
  logic [7:0] awAddr = 8'h00, arAddr = 8'h00;
  logic [31:0] wData = 32'h0;
  logic awValid = 1'b0, wValid = 1'b0, bReady = 1'b0;
  logic arValid = 1'b0, rReady = 1'b0;
  logic awReady, wReady, bValid, arReady, rValid;
  logic [31:0] rData;
  logic [1:0] bResp, rResp;
  logic [2:0] extPin, lineA, lineB, evt, aOut, aOe, bOut, bOe;
  logic [33:0] expQ[$];
  logic [1:0] expB[$];
  int n_mismatch = 0;
  int checked = 0;

  tcc_timer_core #(.ADDR_W(8)) u_dut (
    .clk(clk), .reset_n(reset_n), .s_axi_awaddr(awAddr),
    .s_axi_awvalid(awValid), .s_axi_awready(awReady),
    .s_axi_wdata(wData), .s_axi_wstrb(4'hf), .s_axi_wvalid(wValid),
    .s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid),
    .s_axi_bready(bReady), .s_axi_araddr(arAddr),
    .s_axi_arvalid(arValid), .s_axi_arready(arReady),
    .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid),
    .s_axi_rready(rReady), .extClockPin(extPin), .lineAIn(lineA),
    .lineBIn(lineB), .periphEvent(evt), .lineAOut(aOut),
    .lineAOe(aOe), .lineBOut(bOut), .lineBOe(bOe)
  );
  tcc_sig_src u_src (
    .clk(clk), .extClk(extPin), .lineA(lineA), .lineB(lineB),
    .evt(evt)
  );

  // ----------------------------------------
  // Clock, checks and bus tasks
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic chk(input string what, input logic [33:0] seen,
                     input logic [33:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Ready waits a random 0..2 cycles so held answers get exercised
  task automatic axWr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] er);
    int dly;
    dly = $urandom_range(2);
    expB.push_back(er);
    @(posedge clk);
    awAddr <= a;
    wData <= d;
    awValid <= 1'b1;
    wValid <= 1'b1;
    // Ready drops at the taking edge itself, never assigned twice
    do begin
      @(posedge clk);
      if (awReady) awValid <= 1'b0;
      if (wReady) wValid <= 1'b0;
      if (bReady && bValid) bReady <= 1'b0;
      else if (dly == 0) bReady <= 1'b1;
      else dly--;
    end while (!(bReady && bValid));
  endtask
  // Expected word is queued; the monitor compares on arrival
  task automatic axRd(input logic [7:0] a, input logic [33:0] e);
    int dly;
    dly = $urandom_range(2);
    expQ.push_back(e);
    @(posedge clk);
    arAddr <= a;
    arValid <= 1'b1;
    do begin
      @(posedge clk);
      if (arReady) arValid <= 1'b0;
      if (rReady && rValid) rReady <= 1'b0;
      else if (dly == 0) rReady <= 1'b1;
      else dly--;
    end while (!(rReady && rValid));
  endtask
  // Bus monitor: oldest note against response and data
  always @(posedge clk) begin
    if (rValid === 1'b1 && rReady === 1'b1) begin
      if (expQ.size() == 0) chk("stray read", 34'h1, 34'h0);
      else chk("read", {rResp, rData}, expQ.pop_front());
    end
    if (bValid === 1'b1 && bReady === 1'b1) begin
      if (expB.size() == 0) chk("stray write", 34'h1, 34'h0);
      else chk("bresp", {32'h0, bResp}, {32'h0, expB.pop_front()});
    end
  end
  task automatic end_of_test;
    if (expQ.size() != 0 || expB.size() != 0) n_mismatch++;
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Whole run needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    end_of_test;
  end

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    logic [15:0] rv;
    void'($urandom(32'he6b28dec));
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    // Reset value, unmapped place, random compare round trip
    axRd(8'h84, 34'h0);
    axRd(8'h88, {2'h2, 32'h0});
    axWr(8'h88, 32'h1, 2'h2);
    rv = 16'($urandom);
    axWr(8'h5c, {16'h0, rv}, 2'h0);
    axRd(8'h5c, {18'h0, rv});
    // Enable, then trigger on each external clock choice
    axWr(8'h00, 32'h1, 2'h0);
    axRd(8'h20, 34'h10000);
    for (int k = 0; k < 3; k++) begin
      axWr(8'h04, 32'(5 + k), 2'h0);
      axWr(8'h00, 32'h4, 2'h0);
      axRd(8'h10, 34'(k == 0 ? 0 : k + 1));
      u_src.clkPulses(k, k + 3);
      axRd(8'h10, 34'(k + 2));
    end
    // External clock 0 fed from line A of channel 1
    axWr(8'hc4, 32'h1, 2'h0);
    axWr(8'h04, 32'h5, 2'h0);
    axWr(8'h00, 32'h4, 2'h0);
    repeat (3) u_src.aPulse(1, 1'b0);
    axRd(8'h10, 34'h2);
    axWr(8'hc4, 32'h0, 2'h0);
    // Capture via event input, then reload from the pin unread
    axWr(8'h04, 32'h90007, 2'h0);
    u_src.aPulse(0, 1'b1);
    u_src.clkPulses(2, 2);
    u_src.aPulse(0, 1'b0);
    axRd(8'h20, 34'h10002);
    axRd(8'h14, 34'h4);
    axRd(8'h18, 34'h4);
    // B load switches the clock off; trigger then leaves the count at 4
    axWr(8'h04, 32'h90087, 2'h0);
    u_src.aPulse(0, 1'b0);
    axRd(8'h20, 34'h0);
    axWr(8'h00, 32'h4, 2'h0);
    u_src.clkPulses(2, 2);
    axRd(8'h10, 34'h4);
    // Re-enable, block sync restarts the count
    axWr(8'h00, 32'h1, 2'h0);
    axWr(8'hc0, 32'h1, 2'h0);
    u_src.clkPulses(2, 3);
    axRd(8'h10, 34'h2);
    // Burst gate on a low pin holds the count
    axWr(8'h04, 32'h17, 2'h0);
    axWr(8'h00, 32'h4, 2'h0);
    u_src.clkPulses(2, 2);
    axRd(8'h10, 34'h2);
    // Compare C of 1 retriggers, so five edges end on zero
    axWr(8'h1c, 32'h1, 2'h0);
    axWr(8'h04, 32'h1007, 2'h0);
    u_src.clkPulses(2, 5);
    axRd(8'h10, 34'h0);
    // Line A rising edge as capture trigger
    axWr(8'h04, 32'h507, 2'h0);
    u_src.aPulse(0, 1'b0);
    u_src.clkPulses(2, 1);
    axRd(8'h10, 34'h0);
    // B load stops the clock; a trigger starts it again
    axWr(8'h04, 32'h90047, 2'h0);
    u_src.aPulse(0, 1'b0);
    u_src.clkPulses(2, 2);
    axRd(8'h10, 34'h0);
    axWr(8'h00, 32'h4, 2'h0);
    u_src.clkPulses(2, 2);
    axRd(8'h10, 34'h1);
    // Wave mode on channel 2 turns its lines to outputs
    axWr(8'h84, 32'h8400, 2'h0);
    chk("lineOe", {28'h0, bOe, aOe}, 34'h24);
    chk("lineOut", {28'h0, bOut, aOut}, 34'h0);
    axRd(8'h84, 34'h8400);
    @(posedge clk);
    end_of_test;
  end
endmodule
`default_nettype wire
